// [dpw_map.svh]
// register offsets, reset values and timing constants of the dual process-data watchdog
`ifndef DPW_MAP_SVH
`define DPW_MAP_SVH

// =====================================================================
// register offsets (byte addresses)
`define DPW_TICK_DIVIDER_OFS     12'h400
`define DPW_LOCAL_COUNT_OFS      12'h410
`define DPW_NETWORK_COUNT_OFS    12'h420
`define DPW_CONTROL_OFS          12'h430
`define DPW_STATUS_OFS           12'h434
`define DPW_IRQ_MASK_OFS         12'h438

// =====================================================================
// reset values
`define DPW_TICK_DIVIDER_RST     16'h09c2
`define DPW_LOCAL_COUNT_RST      16'h03e8
`define DPW_NETWORK_COUNT_RST    16'h03e8
`define DPW_CONTROL_RST          2'h3

// =====================================================================
// field positions
`define DPW_CTL_NET_EN_BIT       0
`define DPW_CTL_LOC_EN_BIT       1
`define DPW_ST_NET_TIMEOUT_BIT   0
`define DPW_ST_LOC_TIMEOUT_BIT   1

// =====================================================================
// timing: base period 40 ns, system clock 8 ns, tick = divider + 2 base periods
`define DPW_BASE_PERIOD_PS       40000
`define DPW_MCLK_PERIOD_PS       8000
`define DPW_BASE_CYCLES          (`DPW_BASE_PERIOD_PS / `DPW_MCLK_PERIOD_PS)
`define DPW_TICK_EXTRA           2

`endif

// [dpw_pkg.sv]
// types shared by the dual process-data watchdog
package dpw_pkg;
   typedef logic [15:0] dpw_count_t;
   typedef enum logic [1:0] {
      DPW_IDLE    = 2'b00,
      DPW_RUNNING = 2'b01,
      DPW_EXPIRED = 2'b10
   } dpw_state_e;
endpackage

// [dpw_timer.sv]
// one watchdog timer channel counting shared ticks
`timescale 1ns/1ps
`include "dpw_map.svh"

module dpw_timer (
   input  wire logic               mclk,
   input  wire logic               rstn,
   input  wire logic               enable,
   input  wire logic               tick,
   input  wire logic               restart,
   input  wire dpw_pkg::dpw_count_t limit,
   output logic                    expired,
   output logic                    expireEvent
);
   dpw_pkg::dpw_state_e state_q, state_d;
   dpw_pkg::dpw_count_t count_q, count_d;
   logic                event_q, event_d;

   // =====================================================================
   // next state: restart clears, ticks advance, reaching limit expires
   always_comb begin
      state_d = state_q;
      count_d = count_q;
      event_d = 1'b0;
      case (state_q)
         dpw_pkg::DPW_IDLE: begin
            count_d = 16'h0000;
            if (enable && limit != 16'h0000) begin
               state_d = dpw_pkg::DPW_RUNNING;
            end
         end
         dpw_pkg::DPW_RUNNING: begin
            if (!enable || limit == 16'h0000) begin
               state_d = dpw_pkg::DPW_IDLE;   // zero count disables
            end else if (restart) begin
               count_d = 16'h0000;
            end else if (tick) begin
               if (count_q + 16'h0001 >= limit) begin
                  state_d = dpw_pkg::DPW_EXPIRED;
                  event_d = 1'b1;
               end
               count_d = count_q + 16'h0001;
            end
         end
         dpw_pkg::DPW_EXPIRED: begin
            if (!enable || limit == 16'h0000) begin
               state_d = dpw_pkg::DPW_IDLE;
            end else if (restart) begin
               state_d = dpw_pkg::DPW_RUNNING;
               count_d = 16'h0000;
            end
         end
         default: state_d = dpw_pkg::DPW_IDLE;
      endcase
   end

   // registers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_q <= dpw_pkg::DPW_IDLE;
         count_q <= 16'h0000;
         event_q <= 1'b0;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
         event_q <= event_d;
      end
   end

   assign expired     = (state_q == dpw_pkg::DPW_EXPIRED);
   assign expireEvent = event_q;
endmodule

// [dpw_watchdog.sv]
// dual process-data watchdog with shared tick prescaler and apb registers
// Functional notes
// - two independent watchdogs: network traffic and local process interface
// - network watchdog defaults to 100 ms timeout
// - local interface watchdog defaults to 100 ms timeout
// - only a successful network process-data access restarts network watchdog
// - network timeout raises flag and forces the output data to zero
// - network timeout leaves operational state untouched
// - local interface silence beyond its time flags local timeout
// - one shared divider generates the tick for both watchdogs
// - each watchdog has own count; period is count times tick
// - tick lasts divider plus two base periods of 40 ns
// - divider resets to 2498, giving a 100 us tick
// - network count resets to 1000, giving 100 ms
// - divider at 400h, local count 410h, network count 420h
// - network count of zero disables that watchdog entirely
// - counts accept full 16-bit unsigned range
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "dpw_map.svh"

module dpw_watchdog (
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        networkAccessOk,
   input  wire logic        localInterfaceAccess,
   input  wire logic [15:0] outputDataIn,
   input  wire logic        operationalStateIn,
   output logic [15:0]      outputDataOut,
   output logic             operationalStateOut,
   output logic             networkTimeout,
   output logic             localTimeout,
   output logic             irq
);
   // base period divider width: 5 mclk cycles per 40 ns
   localparam int BASE_CYCLES = `DPW_BASE_CYCLES;

   logic [15:0] divider_q, divider_d;
   logic [15:0] localCount_q, localCount_d;
   logic [15:0] netCount_q, netCount_d;
   logic [1:0]  control_q, control_d;
   logic [1:0]  status_q, status_d;
   logic [1:0]  mask_q, mask_d;
   logic [31:0] prdata_q, prdata_d;
   logic        pready_q, pready_d;
   logic        pslverr_q, pslverr_d;
   logic [2:0]  basePre_q, basePre_d;
   logic [16:0] tickCnt_q, tickCnt_d;
   logic        tick_q, tick_d;
   logic [15:0] outData_q, outData_d;
   logic        opState_q, opState_d;
   logic        irq_q, irq_d;
   logic        netTo_q, locTo_q;
   logic        netExpired, locExpired, netEvent, locEvent;
   logic        setup, wrStrobe;

   // decode an address into a known register; used by read and write paths
   function automatic logic known_addr(input logic [11:0] a);
      known_addr = (a == `DPW_TICK_DIVIDER_OFS) || (a == `DPW_LOCAL_COUNT_OFS) ||
                   (a == `DPW_NETWORK_COUNT_OFS) || (a == `DPW_CONTROL_OFS) ||
                   (a == `DPW_STATUS_OFS) || (a == `DPW_IRQ_MASK_OFS);
   endfunction

   // =====================================================================
   // apb slave: one wait state, answer in the second access cycle
   assign setup    = psel && penable && !pready_q;
   assign wrStrobe = setup && pwrite && known_addr(paddr);

   // bus next values; settings hold until software writes them
   always_comb begin
      divider_d    = divider_q;
      localCount_d = localCount_q;
      netCount_d   = netCount_q;
      control_d    = control_q;
      mask_d       = mask_q;
      prdata_d     = prdata_q;
      pready_d     = setup;
      pslverr_d    = setup && !known_addr(paddr);
      if (wrStrobe) begin
         case (paddr)
            `DPW_TICK_DIVIDER_OFS:  divider_d    = pwdata[15:0];
            `DPW_LOCAL_COUNT_OFS:   localCount_d = pwdata[15:0];
            `DPW_NETWORK_COUNT_OFS: netCount_d   = pwdata[15:0];
            `DPW_CONTROL_OFS:       control_d    = pwdata[1:0];
            `DPW_IRQ_MASK_OFS:      mask_d       = pwdata[1:0];
            default:                control_d    = control_q;
         endcase
      end
      if (setup && !pwrite) begin
         case (paddr)
            `DPW_TICK_DIVIDER_OFS:  prdata_d = {16'h0000, divider_q};
            `DPW_LOCAL_COUNT_OFS:   prdata_d = {16'h0000, localCount_q};
            `DPW_NETWORK_COUNT_OFS: prdata_d = {16'h0000, netCount_q};
            `DPW_CONTROL_OFS:       prdata_d = {30'h0, control_q};
            `DPW_STATUS_OFS:        prdata_d = {30'h0, status_q};
            `DPW_IRQ_MASK_OFS:      prdata_d = {30'h0, mask_q};
            default:                prdata_d = 32'h0000_0000;
         endcase
      end
   end

   // sticky status: hardware set wins over write-one-to-clear
   always_comb begin
      status_d = status_q;
      if (wrStrobe && paddr == `DPW_STATUS_OFS) begin
         status_d = status_q & ~pwdata[1:0];
      end
      if (netEvent) begin
         status_d[`DPW_ST_NET_TIMEOUT_BIT] = 1'b1;
      end
      if (locEvent) begin
         status_d[`DPW_ST_LOC_TIMEOUT_BIT] = 1'b1;
      end
      irq_d = |(status_d & mask_q);
   end

   // =====================================================================
   // shared prescaler: base 40 ns strobe, tick every divider+2 strobes
   always_comb begin
      tick_d    = 1'b0;
      tickCnt_d = tickCnt_q;
      basePre_d = basePre_q + 3'h1;
      if (basePre_q == 3'(BASE_CYCLES - 1)) begin
         basePre_d = 3'h0;
         if (tickCnt_q + 17'h00001 >= {1'b0, divider_q} + 17'd`DPW_TICK_EXTRA) begin
            tickCnt_d = 17'h00000;
            tick_d    = 1'b1;
         end else begin
            tickCnt_d = tickCnt_q + 17'h00001;
         end
      end
   end

   // =====================================================================
   // output gating: zeroed while network watchdog expired, state passes through
   always_comb begin
      outData_d = netExpired ? 16'h0000 : outputDataIn;
      opState_d = operationalStateIn;
   end

   // all registers of the top level
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         divider_q    <= `DPW_TICK_DIVIDER_RST;
         localCount_q <= `DPW_LOCAL_COUNT_RST;
         netCount_q   <= `DPW_NETWORK_COUNT_RST;
         control_q    <= `DPW_CONTROL_RST;
         status_q     <= 2'h0;
         mask_q       <= 2'h0;
         prdata_q     <= 32'h0000_0000;
         pready_q     <= 1'b0;
         pslverr_q    <= 1'b0;
         basePre_q    <= 3'h0;
         tickCnt_q    <= 17'h00000;
         tick_q       <= 1'b0;
         outData_q    <= 16'h0000;
         opState_q    <= 1'b0;
         irq_q        <= 1'b0;
         netTo_q      <= 1'b0;
         locTo_q      <= 1'b0;
      end else begin
         divider_q    <= divider_d;
         localCount_q <= localCount_d;
         netCount_q   <= netCount_d;
         control_q    <= control_d;
         status_q     <= status_d;
         mask_q       <= mask_d;
         prdata_q     <= prdata_d;
         pready_q     <= pready_d;
         pslverr_q    <= pslverr_d;
         basePre_q    <= basePre_d;
         tickCnt_q    <= tickCnt_d;
         tick_q       <= tick_d;
         outData_q    <= outData_d;
         opState_q    <= opState_d;
         irq_q        <= irq_d;
         netTo_q      <= netExpired;
         locTo_q      <= locExpired;
      end
   end

   // =====================================================================
   // two independent channels sharing one tick
   dpw_timer networkTimer (
      .mclk        (mclk),
      .rstn        (rstn),
      .enable      (control_q[`DPW_CTL_NET_EN_BIT]),
      .tick        (tick_q),
      .restart     (networkAccessOk),
      .limit       (netCount_q),
      .expired     (netExpired),
      .expireEvent (netEvent)
   );

   dpw_timer localTimer (
      .mclk        (mclk),
      .rstn        (rstn),
      .enable      (control_q[`DPW_CTL_LOC_EN_BIT]),
      .tick        (tick_q),
      .restart     (localInterfaceAccess),
      .limit       (localCount_q),
      .expired     (locExpired),
      .expireEvent (locEvent)
   );

   // outputs straight from their flip-flops
   assign pready              = pready_q;
   assign prdata              = prdata_q;
   assign pslverr             = pslverr_q;
   assign outputDataOut       = outData_q;
   assign operationalStateOut = opState_q;
   assign networkTimeout      = netTo_q;
   assign localTimeout        = locTo_q;
   assign irq                 = irq_q;
endmodule

// [dpw_watchdog_checker.sv]
// port-level checks of the dual process-data watchdog
`timescale 1ns/1ps
module dpw_watchdog_checker (
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        networkAccessOk,
   input wire logic        localInterfaceAccess,
   input wire logic [15:0] outputDataIn,
   input wire logic        operationalStateIn,
   input wire logic [15:0] outputDataOut,
   input wire logic        operationalStateOut,
   input wire logic        networkTimeout,
   input wire logic        localTimeout
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // ==========================================
   // register bus handshake
   sequence sAccess;
      psel && penable && !pready;
   endsequence
   sequence sDone;
      pready ##1 !pready;
   endsequence
   a_apb_ready_wait: assert property (sAccess |=> sDone) else $error("pready not one cycle after access");
   a_apb_idle_quiet: assert property (!psel |=> !pready) else $error("pready without select");
   a_apb_err_ready: assert property (pslverr |-> pready) else $error("pslverr outside pready");
   // ==========================================
   // outputs, state and restarts; the first cycle after reset or after a clear is left out
   a_out_forced_zero: assert property (networkTimeout |-> outputDataOut == 16'h0000) else $error("outputs live in timeout");
   a_out_pass_through: assert property ($past(rstn) && !networkTimeout && !$past(networkTimeout) |-> outputDataOut == $past(outputDataIn)) else $error("outputs not passed");
   a_state_kept: assert property ($past(rstn) |-> operationalStateOut == $past(operationalStateIn)) else $error("state disturbed");
   a_net_restart_clears: assert property (networkAccessOk |-> ##[1:3] !networkTimeout) else $error("network timeout kept");
   a_loc_restart_clears: assert property (localInterfaceAccess |-> ##[1:3] !localTimeout) else $error("local timeout kept");
endmodule
bind dpw_watchdog dpw_watchdog_checker chk (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .networkAccessOk(networkAccessOk), .localInterfaceAccess(localInterfaceAccess),
   .outputDataIn(outputDataIn), .operationalStateIn(operationalStateIn), .outputDataOut(outputDataOut),
   .operationalStateOut(operationalStateOut), .networkTimeout(networkTimeout), .localTimeout(localTimeout));

// [dpw_far_side.sv]
// far-side model: network master and local application making periodic accesses
`timescale 1ns/1ps
module dpw_far_side (
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic [7:0] netGap,
   input  wire logic [7:0] locGap,
   output logic            networkAccessOk,
   output logic            localInterfaceAccess
);
   logic [7:0] netCnt_q;
   logic [7:0] locCnt_q;
   // one-cycle access every gap cycles; a gap of zero means silence, as on a broken line
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         netCnt_q <= 8'h00;
         locCnt_q <= 8'h00;
         networkAccessOk <= 1'b0;
         localInterfaceAccess <= 1'b0;
      end else begin
         netCnt_q <= (netCnt_q + 8'h01 >= netGap) ? 8'h00 : netCnt_q + 8'h01;
         locCnt_q <= (locCnt_q + 8'h01 >= locGap) ? 8'h00 : locCnt_q + 8'h01;
         networkAccessOk <= (netGap != 8'h00) && (netCnt_q == 8'h00);
         localInterfaceAccess <= (locGap != 8'h00) && (locCnt_q == 8'h00);
      end
   end
endmodule

// [dual_process_data_watchdog_bench.sv]
// self-checking bench for the dual process-data watchdog
`timescale 1ns/1ps
`include "dpw_map.svh"
module dual_process_data_watchdog_bench;
   logic        mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, operationalStateIn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] outputDataIn = 16'h0000, outputDataOut;
   logic        pready, pslverr, networkTimeout, localTimeout, irq, operationalStateOut, err;
   logic        networkAccessOk, localInterfaceAccess;
   logic [7:0]  netGap = 8'h00, locGap = 8'h00;
   logic [11:0] ofs [6] = '{12'h400, 12'h410, 12'h420, 12'h430, 12'h434, 12'h438};
   logic [15:0] rstv [6] = '{16'h09c2, 16'h03e8, 16'h03e8, 16'h0003, 16'h0000, 16'h0000};
   int          n_fail = 0, n_checks = 0, n;

   always #4 mclk = ~mclk;

   dpw_watchdog uut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .networkAccessOk(networkAccessOk),
      .localInterfaceAccess(localInterfaceAccess), .outputDataIn(outputDataIn),
      .operationalStateIn(operationalStateIn), .outputDataOut(outputDataOut),
      .operationalStateOut(operationalStateOut), .networkTimeout(networkTimeout), .localTimeout(localTimeout), .irq(irq));
   dpw_far_side far (.mclk(mclk), .rstn(rstn), .netGap(netGap), .locGap(locGap), .networkAccessOk(networkAccessOk),
      .localInterfaceAccess(localInterfaceAccess));

   // ==========================================
   // compare, bus and wait helpers
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // request held until pready is seen; no fixed latency assumed, only the hang guard ends a wait
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task waitTo(input logic loc);
      n = 0;
      while ((loc ? localTimeout : networkTimeout) !== 1'b1 && n < 100) begin
         @(posedge mclk);
         n++;
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #100000;
      n_fail++;
      print_verdict;
   end

   // ==========================================
   // test sequence
   initial begin
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      outputDataIn <= 16'ha5c3;
      operationalStateIn <= 1'b1;
      netGap <= 8'd5;
      locGap <= 8'd5;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, ofs[i], 32'h0);
         chk("reset value", {16'h0000, rstv[i]}, rd);
      end
      apb(1'b0, 12'h404, 32'hffffffff);
      chk("unmapped read", 32'h0, rd);
      chk("unmapped error", 32'h1, err);
      // startup load; divider 0 gives a 10-cycle tick
      apb(1'b1, `DPW_NETWORK_COUNT_OFS, 32'hffff);
      apb(1'b0, `DPW_NETWORK_COUNT_OFS, 32'h0);
      chk("full count", 32'hffff, rd);
      apb(1'b1, `DPW_TICK_DIVIDER_OFS, 32'h0);
      apb(1'b1, `DPW_LOCAL_COUNT_OFS, 32'h4);
      apb(1'b1, `DPW_NETWORK_COUNT_OFS, 32'h3);
      apb(1'b1, `DPW_IRQ_MASK_OFS, 32'h3);
      repeat (200) @(posedge mclk);
      chk("net quiet", 32'h0, networkTimeout);
      chk("loc quiet", 32'h0, localTimeout);
      // network silence, restarts every cycle just before so the span is tight
      netGap <= 8'd1;
      repeat (3) @(posedge mclk);
      netGap <= 8'd0;
      waitTo(1'b0);
      chk("net span", 32'h1, n >= 19 && n <= 34);
      @(posedge mclk);
      chk("outputs off", 32'h0, outputDataOut);
      chk("state kept", 32'h1, operationalStateOut);
      chk("loc apart", 32'h0, localTimeout);
      chk("irq up", 32'h1, irq);
      apb(1'b0, `DPW_STATUS_OFS, 32'h0);
      chk("status", 32'h1, rd);
      apb(1'b1, `DPW_IRQ_MASK_OFS, 32'h2);
      repeat (2) @(posedge mclk);
      chk("irq masked", 32'h0, irq);
      netGap <= 8'd5;
      repeat (10) @(posedge mclk);
      chk("net restart", 32'h0, networkTimeout);
      chk("outputs back", 32'ha5c3, outputDataOut);
      apb(1'b1, `DPW_STATUS_OFS, 32'h1);
      apb(1'b0, `DPW_STATUS_OFS, 32'h0);
      chk("status cleared", 32'h0, rd);
      // local silence leaves outputs alone
      locGap <= 8'd0;
      waitTo(1'b1);
      chk("loc span", 32'h1, n >= 25 && n <= 44);
      repeat (2) @(posedge mclk);
      chk("outputs kept", 32'ha5c3, outputDataOut);
      chk("irq local", 32'h1, irq);
      // clearing the enable bit drops a pending local timeout
      apb(1'b1, `DPW_CONTROL_OFS, 32'h1);
      repeat (2) @(posedge mclk);
      chk("loc disabled", 32'h0, localTimeout);
      apb(1'b1, `DPW_CONTROL_OFS, 32'h3);
      locGap <= 8'd5;
      // a zero count switches the network watchdog off
      apb(1'b1, `DPW_NETWORK_COUNT_OFS, 32'h0);
      netGap <= 8'd0;
      repeat (100) @(posedge mclk);
      chk("zero count off", 32'h0, networkTimeout);
      // second reset in mid-run brings the startup settings back
      rstn <= 1'b0;
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      apb(1'b0, `DPW_NETWORK_COUNT_OFS, 32'h0);
      chk("net count after reset", {16'h0000, `DPW_NETWORK_COUNT_RST}, rd);
      apb(1'b0, `DPW_TICK_DIVIDER_OFS, 32'h0);
      chk("divider after reset", {16'h0000, `DPW_TICK_DIVIDER_RST}, rd);
      print_verdict;
   end
endmodule
